// >>> common/wdtr_pkg.sv
// Register map, field positions, reset values and timing constants of the watchdog.
package wdtr_pkg;
    localparam logic [11:0] RELOAD_OFS = 12'h000;
    localparam logic [11:0] COUNT_OFS = 12'h004;
    localparam logic [11:0] CTRL_OFS = 12'h008;
    localparam logic [11:0] CLEAR_OFS = 12'h00c;
    localparam logic [11:0] RAW_OFS = 12'h010;
    localparam logic [11:0] MASKED_OFS = 12'h014;
    localparam logic [11:0] EVT_STATUS_OFS = 12'h018;
    localparam logic [11:0] EVT_MASK_OFS = 12'h01c;
    localparam logic [11:0] LOCK_OFS = 12'hc00;

    localparam logic [31:0] RELOAD_RESET = 32'h0fffffff;
    localparam logic [31:0] COUNT_RESET = 32'h0fffffff;
    localparam logic [31:0] UNLOCK_KEY = 32'h1acce551;
    localparam logic [31:0] ZERO_WORD = 32'h00000000;

    localparam int IRQ_ENABLE_BIT = 0;
    localparam int RESET_ENABLE_BIT = 1;
    localparam int RAW_IRQ_BIT = 0;
    localparam int MASKED_IRQ_BIT = 0;
    localparam int EVT_TIMEOUT_BIT = 0;
    localparam int EVT_RESET_BIT = 1;
    localparam int EVT_WIDTH = 2;

    localparam logic [EVT_WIDTH-1:0] EVT_RESET_VAL = 2'h0;
    localparam logic [EVT_WIDTH-1:0] EVT_MASK_RESET = 2'h0;

    localparam int PCLK_HZ = 50_000_000;
    localparam int COUNT_CLK_HZ = 32_768;
    localparam int TICK_DIV = (PCLK_HZ + COUNT_CLK_HZ / 2) / COUNT_CLK_HZ;
    localparam int DIV_WIDTH = 11;
    localparam logic [DIV_WIDTH-1:0] DIV_LAST = DIV_WIDTH'(TICK_DIV - 1);
    localparam logic [DIV_WIDTH-1:0] DIV_RESET = 11'h000;
endpackage : wdtr_pkg

// >>> src/wdtr_watchdog.sv
// Watchdog timer with APB register interface, write lock and event interrupt.
//
// How it works
// - Reload register write restarts count from it.
// - Reload and count reset to 0x0FFFFFFF.
// - Count register reads live counter, ignores writes.
// - Control bit 0 enables timeout interrupt.
// - Control bit 1 gates system reset output.
// - Any clear write clears interrupt, reloads counter.
// - Clear register always reads zero.
// - Raw status bit shows unmasked interrupt.
// - Masked status bit shows interrupt after masking.
// - Lock register reads one while writes blocked.
// - Only the key unblocks register writes.
// - Any other lock value blocks register writes.
// - Zero count raises interrupt and reloads counter.
// - Second uncleared timeout asserts reset if enabled.
// - Disabled counter stands; enabling reloads it.
// - Counter decrements once per count clock tick.
//
// Decided for this implementation: the APB register port.
module wdtr_watchdog (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic wdt_reset
);
    localparam int EVT_WIDTH_L = wdtr_pkg::EVT_WIDTH;

    logic [31:0] reload_q;
    logic [31:0] count_q;
    logic irq_enable_q;
    logic reset_enable_q;
    logic raw_irq_q;
    logic lock_q;
    logic wdt_reset_q;
    logic [EVT_WIDTH_L-1:0] evt_q;
    logic [EVT_WIDTH_L-1:0] evt_mask_q;
    logic [31:0] prdata_q;
    logic [wdtr_pkg::DIV_WIDTH-1:0] div_q;
    logic tick_q;

    logic sel_reload;
    logic sel_count;
    logic sel_ctrl;
    logic sel_clear;
    logic sel_raw;
    logic sel_masked;
    logic sel_evt;
    logic sel_mask;
    logic sel_lock;
    logic addr_hit;
    logic acc_wr;
    logic wr_open;
    logic wr_reload;
    logic wr_ctrl;
    logic wr_clear;
    logic wr_evt;
    logic wr_mask;
    logic wr_lock;
    logic rd_setup;
    logic restart;
    logic timeout;
    logic reset_fire;
    logic masked_irq;
    logic [EVT_WIDTH_L-1:0] evt_set;
    logic [EVT_WIDTH_L-1:0] evt_clr;
    logic [31:0] rd_mux;

    assign sel_reload = paddr == wdtr_pkg::RELOAD_OFS;
    assign sel_count = paddr == wdtr_pkg::COUNT_OFS;
    assign sel_ctrl = paddr == wdtr_pkg::CTRL_OFS;
    assign sel_clear = paddr == wdtr_pkg::CLEAR_OFS;
    assign sel_raw = paddr == wdtr_pkg::RAW_OFS;
    assign sel_masked = paddr == wdtr_pkg::MASKED_OFS;
    assign sel_evt = paddr == wdtr_pkg::EVT_STATUS_OFS;
    assign sel_mask = paddr == wdtr_pkg::EVT_MASK_OFS;
    assign sel_lock = paddr == wdtr_pkg::LOCK_OFS;
    assign addr_hit = sel_reload | sel_count | sel_ctrl | sel_clear | sel_raw
        | sel_masked | sel_evt | sel_mask | sel_lock;

    // Writes take effect at the edge that closes the access phase.
    assign acc_wr = psel & penable & pwrite;
    assign wr_open = acc_wr & ~lock_q;
    assign wr_reload = wr_open & sel_reload;
    assign wr_ctrl = wr_open & sel_ctrl;
    assign wr_clear = wr_open & sel_clear;
    assign wr_evt = wr_open & sel_evt;
    assign wr_mask = wr_open & sel_mask;
    assign wr_lock = acc_wr & sel_lock;
    assign rd_setup = psel & ~penable & ~pwrite;

    assign restart = wr_ctrl & pwdata[wdtr_pkg::IRQ_ENABLE_BIT] & ~irq_enable_q;
    assign timeout = tick_q & irq_enable_q & (count_q == wdtr_pkg::ZERO_WORD);
    assign reset_fire = timeout & raw_irq_q & reset_enable_q;
    assign masked_irq = raw_irq_q & irq_enable_q;

    // Count clock as a one-cycle enable from a divider of pclk.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_q <= wdtr_pkg::DIV_RESET;
            tick_q <= 1'b0;
        end
        else if (div_q == wdtr_pkg::DIV_LAST)
        begin
            div_q <= wdtr_pkg::DIV_RESET;
            tick_q <= 1'b1;
        end
        else
        begin
            div_q <= div_q + 11'h001;
            tick_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            reload_q <= wdtr_pkg::RELOAD_RESET;
        end
        else if (wr_reload)
        begin
            reload_q <= pwdata;
        end
    end

    // Counter: a reload write wins, then clear or enable, then timeout.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count_q <= wdtr_pkg::COUNT_RESET;
        end
        else if (wr_reload)
        begin
            count_q <= pwdata;
        end
        else if (wr_clear || restart)
        begin
            count_q <= reload_q;
        end
        else if (timeout)
        begin
            count_q <= reload_q;
        end
        else if (tick_q && irq_enable_q)
        begin
            count_q <= count_q - 32'h00000001;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_enable_q <= 1'b0;
            reset_enable_q <= 1'b0;
        end
        else if (wr_ctrl)
        begin
            irq_enable_q <= pwdata[wdtr_pkg::IRQ_ENABLE_BIT];
            reset_enable_q <= pwdata[wdtr_pkg::RESET_ENABLE_BIT];
        end
    end

    // A timeout in the same cycle as a clear keeps the interrupt set.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            raw_irq_q <= 1'b0;
        end
        else if (timeout)
        begin
            raw_irq_q <= 1'b1;
        end
        else if (wr_clear)
        begin
            raw_irq_q <= 1'b0;
        end
    end

    // The reset output holds until the system reset returns.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wdt_reset_q <= 1'b0;
        end
        else if (reset_fire)
        begin
            wdt_reset_q <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lock_q <= 1'b0;
        end
        else if (wr_lock)
        begin
            lock_q <= pwdata != wdtr_pkg::UNLOCK_KEY;
        end
    end

    assign evt_set = {reset_fire, timeout};
    assign evt_clr = wr_evt ? pwdata[EVT_WIDTH_L-1:0] : wdtr_pkg::EVT_RESET_VAL;

    // Sticky events: a new event wins over a write-one clear.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            evt_q <= wdtr_pkg::EVT_RESET_VAL;
        end
        else
        begin
            evt_q <= (evt_q & ~evt_clr) | evt_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            evt_mask_q <= wdtr_pkg::EVT_MASK_RESET;
        end
        else if (wr_mask)
        begin
            evt_mask_q <= pwdata[EVT_WIDTH_L-1:0];
        end
    end

    always_comb
    begin
        rd_mux = wdtr_pkg::ZERO_WORD;
        case (paddr)
            wdtr_pkg::RELOAD_OFS: rd_mux = reload_q;
            wdtr_pkg::COUNT_OFS: rd_mux = count_q;
            wdtr_pkg::CTRL_OFS:
            begin
                rd_mux[wdtr_pkg::IRQ_ENABLE_BIT] = irq_enable_q;
                rd_mux[wdtr_pkg::RESET_ENABLE_BIT] = reset_enable_q;
            end
            wdtr_pkg::CLEAR_OFS: rd_mux = wdtr_pkg::ZERO_WORD;
            wdtr_pkg::RAW_OFS: rd_mux[wdtr_pkg::RAW_IRQ_BIT] = raw_irq_q;
            wdtr_pkg::MASKED_OFS: rd_mux[wdtr_pkg::MASKED_IRQ_BIT] = masked_irq;
            wdtr_pkg::EVT_STATUS_OFS: rd_mux[EVT_WIDTH_L-1:0] = evt_q;
            wdtr_pkg::EVT_MASK_OFS: rd_mux[EVT_WIDTH_L-1:0] = evt_mask_q;
            wdtr_pkg::LOCK_OFS: rd_mux[0] = lock_q;
            default: rd_mux = wdtr_pkg::ZERO_WORD;
        endcase
    end

    // Read data is captured in the setup cycle and shown in the access phase.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q <= wdtr_pkg::ZERO_WORD;
        end
        else if (rd_setup)
        begin
            prdata_q <= rd_mux;
        end
    end

    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_hit;
    assign irq = |(evt_q & evt_mask_q);
    assign wdt_reset = wdt_reset_q;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_reload_restarts: assert property (wr_reload |=> count_q == $past(pwdata))
        else $error("reload write did not restart the counter");

    a_count_read_live: assert property (
        rd_setup && sel_count |=> prdata == $past(count_q))
        else $error("count read did not return the live count");

    a_clear_reloads: assert property (
        wr_clear && !wr_reload && !timeout |=> !raw_irq_q && count_q == $past(reload_q))
        else $error("clear write did not clear and reload");

    a_clear_reads_zero: assert property (
        rd_setup && sel_clear |=> prdata == 32'h00000000)
        else $error("clear register read was not zero");

    a_raw_read_bit: assert property (
        rd_setup && sel_raw |=> prdata == {31'h0, $past(raw_irq_q)})
        else $error("raw status read wrong");

    a_masked_read_bit: assert property (
        rd_setup && sel_masked |=> prdata == {31'h0, $past(raw_irq_q & irq_enable_q)})
        else $error("masked status read wrong");

    a_lock_read_state: assert property (
        rd_setup && sel_lock |=> prdata == {31'h0, $past(lock_q)})
        else $error("lock register read wrong");

    a_key_unlocks: assert property (
        wr_lock && pwdata == wdtr_pkg::UNLOCK_KEY |=> !lock_q)
        else $error("key write did not unlock");

    a_other_locks: assert property (
        wr_lock && pwdata != wdtr_pkg::UNLOCK_KEY |=> lock_q)
        else $error("non-key write did not lock");

    a_locked_discard: assert property (
        acc_wr && lock_q && (sel_reload || sel_ctrl) |=> $stable(reload_q)
        && $stable(irq_enable_q) && $stable(reset_enable_q))
        else $error("locked write changed a register");

    a_timeout_reload: assert property (
        timeout && !wr_reload |=> raw_irq_q && count_q == $past(reload_q))
        else $error("timeout did not raise and reload");

    a_second_timeout: assert property (
        timeout && raw_irq_q && reset_enable_q |=> wdt_reset ##1 wdt_reset)
        else $error("second timeout did not assert reset");

    a_reset_gated: assert property ($rose(wdt_reset) |-> $past(reset_enable_q))
        else $error("reset asserted while disabled");

    a_stand_disabled: assert property (
        !irq_enable_q && !wr_reload && !wr_clear && !restart |=> $stable(count_q))
        else $error("counter moved while disabled");

    a_enable_reloads: assert property (
        restart && !wr_reload |=> count_q == $past(reload_q))
        else $error("enable did not reload counter");

    a_tick_spacing: assert property (tick_q |=> (!tick_q) [*8])
        else $error("count clock ticks too close");

    a_decrement_step: assert property (
        tick_q && irq_enable_q && count_q != 32'h0 && !wr_reload && !wr_clear
        |=> count_q == $past(count_q) - 32'h1)
        else $error("counter did not decrement by one");

    a_mask_and: assert property (irq_enable_q == 1'b0 |-> !masked_irq)
        else $error("masked status set while disabled");

    a_event_sticky: assert property (timeout |=> evt_q[wdtr_pkg::EVT_TIMEOUT_BIT])
        else $error("timeout did not set its event bit");

    a_locked_clear: assert property (
        acc_wr && lock_q && sel_clear && !timeout |=> raw_irq_q == $past(raw_irq_q))
        else $error("locked clear write changed the interrupt");

    c_timeout: cover property (timeout);
    c_reset_fire: cover property (reset_fire);
    c_locked_write: cover property (acc_wr && lock_q && sel_reload);
    c_clear_after_irq: cover property (raw_irq_q ##1 wr_clear);
endmodule : wdtr_watchdog

// >>> testbench/wdtr_watchdog_tb.sv
// Self-checking testbench of the watchdog register block.
module wdtr_watchdog_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic wdt_reset;
    logic [31:0] rd;
    logic [31:0] held;
    logic err_seen;
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;

    always #10 pclk = ~pclk;

    wdtr_watchdog u_wdtr_watchdog (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .irq(irq),
        .wdt_reset(wdt_reset)
    );

    task automatic end_sim();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
        begin
            $display("verification passed");
        end
        else
        begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH %0t word got %h exp %h", $time, got, exp);
        end
    endtask : chk32

    task automatic chk1(input logic got, input logic exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH %0t bit got %b exp %b", $time, got, exp);
        end
    endtask : chk1

    // One APB transfer; read data and error are taken at the pready edge.
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            @(posedge pclk);
        end
        rd = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] addr, input logic [31:0] data);
        apb(1'b1, addr, data);
    endtask : wr

    task automatic rdchk(input logic [11:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h00000000);
        chk32(rd, exp);
    endtask : rdchk

    // Reads a register until the given bit is set or the tries run out.
    task automatic poll(input logic [11:0] addr, input int b, input int tries);
        for (int i = 0; i < tries; i++)
        begin
            apb(1'b0, addr, 32'h00000000);
            if (rd[b] === 1'b1)
            begin
                break;
            end
        end
    endtask : poll

    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            n_errors++;
            $display("MISMATCH %0t run too long", $time);
            end_sim();
        end
    end

    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(wdtr_pkg::RELOAD_OFS, wdtr_pkg::RELOAD_RESET);
        rdchk(wdtr_pkg::COUNT_OFS, wdtr_pkg::COUNT_RESET);
        rdchk(wdtr_pkg::CTRL_OFS, 32'h00000000);
        rdchk(wdtr_pkg::RAW_OFS, 32'h00000000);
        rdchk(wdtr_pkg::MASKED_OFS, 32'h00000000);
        rdchk(wdtr_pkg::LOCK_OFS, 32'h00000000);
        rdchk(12'h020, 32'h00000000);
        chk1(err_seen, 1'b1);
        chk1(irq, 1'b0);
        wr(wdtr_pkg::COUNT_OFS, 32'h12345678);
        rdchk(wdtr_pkg::COUNT_OFS, wdtr_pkg::COUNT_RESET);
        wr(wdtr_pkg::RAW_OFS, 32'hffffffff);
        rdchk(wdtr_pkg::RAW_OFS, 32'h00000000);
        wr(wdtr_pkg::MASKED_OFS, 32'hffffffff);
        rdchk(wdtr_pkg::MASKED_OFS, 32'h00000000);
        wr(wdtr_pkg::CLEAR_OFS, 32'hffffffff);
        rdchk(wdtr_pkg::CLEAR_OFS, 32'h00000000);
        wr(wdtr_pkg::LOCK_OFS, wdtr_pkg::UNLOCK_KEY ^ 32'h00000001);
        rdchk(wdtr_pkg::LOCK_OFS, 32'h00000001);
        wr(wdtr_pkg::RELOAD_OFS, 32'h00000005);
        rdchk(wdtr_pkg::RELOAD_OFS, wdtr_pkg::RELOAD_RESET);
        wr(wdtr_pkg::CTRL_OFS, 32'h00000003);
        rdchk(wdtr_pkg::CTRL_OFS, 32'h00000000);
        wr(wdtr_pkg::LOCK_OFS, wdtr_pkg::UNLOCK_KEY);
        rdchk(wdtr_pkg::LOCK_OFS, 32'h00000000);
        wr(wdtr_pkg::RELOAD_OFS, 32'h00000002);
        rdchk(wdtr_pkg::RELOAD_OFS, 32'h00000002);
        rdchk(wdtr_pkg::COUNT_OFS, 32'h00000002);
        wr(wdtr_pkg::EVT_MASK_OFS, 32'h00000001);
        wr(wdtr_pkg::CTRL_OFS, 32'hffffffff);
        // Three ticks from a reload of two cannot pass in 3000 cycles.
        repeat (3000) @(posedge pclk);
        rdchk(wdtr_pkg::RAW_OFS, 32'h00000000);
        poll(wdtr_pkg::RAW_OFS, 0, 600);
        chk32(rd, 32'h00000001);
        rdchk(wdtr_pkg::COUNT_OFS, 32'h00000002);
        rdchk(wdtr_pkg::MASKED_OFS, 32'h00000001);
        chk1(irq, 1'b1);
        rdchk(wdtr_pkg::CTRL_OFS, 32'h00000003);
        wr(wdtr_pkg::CLEAR_OFS, 32'h00000000);
        rdchk(wdtr_pkg::RAW_OFS, 32'h00000000);
        rdchk(wdtr_pkg::COUNT_OFS, 32'h00000002);
        wr(wdtr_pkg::EVT_STATUS_OFS, 32'h00000001);
        // The interrupt output settles after the edge that takes the write.
        @(negedge pclk);
        chk1(irq, 1'b0);
        wr(wdtr_pkg::EVT_MASK_OFS, 32'h00000002);
        poll(wdtr_pkg::RAW_OFS, 0, 1700);
        chk32(rd, 32'h00000001);
        chk1(irq, 1'b0);
        chk1(wdt_reset, 1'b0);
        poll(wdtr_pkg::EVT_STATUS_OFS, 1, 1700);
        chk1(wdt_reset, 1'b1);
        chk1(irq, 1'b1);
        rdchk(wdtr_pkg::EVT_STATUS_OFS, 32'h00000003);
        wr(wdtr_pkg::CTRL_OFS, 32'h00000000);
        rdchk(wdtr_pkg::RAW_OFS, 32'h00000001);
        rdchk(wdtr_pkg::MASKED_OFS, 32'h00000000);
        wr(wdtr_pkg::LOCK_OFS, 32'h00000000);
        wr(wdtr_pkg::CLEAR_OFS, 32'h00000000);
        rdchk(wdtr_pkg::RAW_OFS, 32'h00000001);
        wr(wdtr_pkg::LOCK_OFS, wdtr_pkg::UNLOCK_KEY);
        apb(1'b0, wdtr_pkg::COUNT_OFS, 32'h00000000);
        held = rd;
        chk32(held, 32'h00000002);
        repeat (3200) @(posedge pclk);
        rdchk(wdtr_pkg::COUNT_OFS, held);
        wr(wdtr_pkg::CTRL_OFS, 32'h00000001);
        rdchk(wdtr_pkg::COUNT_OFS, 32'h00000002);
        // Stop the count part way down, then re-enable: it must restart from the reload value.
        poll(wdtr_pkg::COUNT_OFS, 0, 600);
        chk32(rd, 32'h00000001);
        wr(wdtr_pkg::CTRL_OFS, 32'h00000000);
        rdchk(wdtr_pkg::COUNT_OFS, 32'h00000001);
        wr(wdtr_pkg::CTRL_OFS, 32'h00000001);
        rdchk(wdtr_pkg::COUNT_OFS, 32'h00000002);
        presetn <= 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        chk1(wdt_reset, 1'b0);
        rdchk(wdtr_pkg::CTRL_OFS, 32'h00000000);
        rdchk(wdtr_pkg::COUNT_OFS, wdtr_pkg::COUNT_RESET);
        end_sim();
    end
endmodule : wdtr_watchdog_tb
